// File: src/oag_top.sv
/*
 * Operand address generation top: registers each address request into a
 * segment and offset, and each operand-format request into checked
 * immediate, register-pair, selector and far-pointer fields.
 * Assumes the core presents requests in step with clk and reads the
 * register file combinationally through the ports given here.
 */
// What this block does
// - Arithmetic ops take an immediate, except both divide kinds.
// - Immediates never exceed an unsigned doubleword or the op's maximum.
// - Quadword pair: high data register upper half, low accumulator lower.
// - Instruction fetches always use the code segment.
// - Pushes and pops always use the stack segment.
// - Stack pointer or frame base as base selects the stack segment.
// - Other data references default to the data segment.
// - String destinations always use the string target segment.
// - A segment prefix replaces the default for data accesses.
// - Explicit selectors are sixteen bits from memory or a register.
// - Far pointer: offset in first doubleword, selector in next word.
// - Displacements come in eight, sixteen and thirty-two bit widths.
// - Index is multiplied by scale one, two, four or eight.
// - Base and index come from general registers.
// - Offset is displacement plus base plus scaled index.
// - Displacement, base and index are signed; scale always positive.
// - Offset counts bytes from segment start to operand's first byte.
// - The stack pointer is never accepted as an index.
// - Any part may be absent; scale only applies with an index.
// - Sixteen-bit address size uses sixteen-bit offsets and displacements.
`timescale 1ns/1ps
`default_nettype none

module oag_top (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               rst,
    // Address request.
    input  wire oag_pkg::oag_req_s  req,
    // Operand-format request.
    input  wire oag_pkg::oag_opnd_s opnd,
    // General register file read ports.
    output logic [2:0]              gpr_rd_a,
    output logic [2:0]              gpr_rd_b,
    input  wire logic [31:0]        gpr_val_a,
    input  wire logic [31:0]        gpr_val_b,
    input  wire logic [31:0]        low_accumulator_register,
    input  wire logic [31:0]        high_data_pair_register,
    input  wire logic [15:0]        gpr_half_sel,
    // Results.
    output oag_pkg::oag_addr_s      addr_out,
    output oag_pkg::oag_opres_s     opnd_out
);
    import oag_pkg::*;

    // Whole registered state of the block.
    typedef struct packed {
        oag_addr_s  addr;
        oag_opres_s opres;
    } oag_state_s;

    oag_state_s state_r;
    oag_state_s state_nxt;
    logic [2:0]  seg_sel;
    logic [31:0] ea_offset;
    logic        index_ok;

    // The immediate is legal for this op and within its limit.
    function automatic logic imm_allowed(input oag_op_e op,
                                         input logic [31:0] imm,
                                         input logic [31:0] lim);
        logic div_op;
        div_op = (op == OAG_OP_UNSIGNED_DIV) ||
                 (op == OAG_OP_SIGNED_QUOTIENT);
        return !div_op && (imm <= lim);
    endfunction

    // Base and index are read from the general registers.
    assign gpr_rd_a = req.base_reg;
    assign gpr_rd_b = req.index_reg;

    // The stack pointer cannot serve as an index.
    assign index_ok = !(req.index_valid && req.index_reg == OAG_REG_STACK_PTR);

    oag_seg_select oag_seg_select_inst (
        .ref_kind   (req.ref_kind),
        .base_valid (req.base_valid),
        .base_reg   (req.base_reg),
        .ovr_valid  (req.ovr_valid),
        .ovr_seg    (req.ovr_seg),
        .seg        (seg_sel)
    );

    oag_ea_adder oag_ea_adder_inst (
        .addr32      (req.addr32),
        .disp_size   (req.disp_size),
        .disp        (req.disp),
        .base_valid  (req.base_valid),
        .base_val    (gpr_val_a),
        .index_valid (req.index_valid),
        .scale       (req.scale),
        .index_val   (gpr_val_b),
        .offset      (ea_offset)
    );

    // Next state from the two requests.
    always_comb begin
        state_nxt = state_r;
        state_nxt.addr.valid = req.valid;
        state_nxt.opres.valid = opnd.valid;
        if (req.valid) begin
            state_nxt.addr.seg    = seg_sel;
            state_nxt.addr.fault  = !index_ok;
            state_nxt.addr.offset = index_ok ? ea_offset : OAG_RST_WORD;
        end
        if (opnd.valid) begin
            state_nxt.opres.imm_fault = opnd.imm_valid &&
                !imm_allowed(opnd.op, opnd.imm, opnd.imm_max);
            state_nxt.opres.imm = (opnd.imm_valid && !state_nxt.opres.imm_fault)
                ? opnd.imm : OAG_RST_WORD;
            state_nxt.opres.pair = {high_data_pair_register,
                                    low_accumulator_register};
            state_nxt.opres.sel = opnd.sel_from_mem ? opnd.sel_mem
                                                    : gpr_half_sel;
            state_nxt.opres.far_off = opnd.far_mem[OAG_WORD_W-1:0];
            state_nxt.opres.far_sel =
                opnd.far_mem[OAG_FAR_W-1:OAG_FAR_SEL_LO];
        end
    end

    // Register the state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign addr_out = state_r.addr;
    assign opnd_out = state_r.opres;

endmodule

`default_nettype wire

// File: src/oag_pkg.sv
/*
 * Package for the operand address generation block: register codes,
 * segment codes, reference kinds, field widths and request/result carriers.
 * Assumes a core that presents one decoded operand request per cycle.
 */
`default_nettype none

package oag_pkg;

    // General register numbers as the register file indexes them.
    localparam logic [2:0] OAG_REG_LOW_ACC   = 3'h0;
    localparam logic [2:0] OAG_REG_HIGH_DATA = 3'h2;
    localparam logic [2:0] OAG_REG_STACK_PTR = 3'h4;
    localparam logic [2:0] OAG_REG_FRAME_BAS = 3'h5;

    // Segment register numbers.
    localparam logic [2:0] OAG_SEG_STRING = 3'h0;
    localparam logic [2:0] OAG_SEG_CODE   = 3'h1;
    localparam logic [2:0] OAG_SEG_STACK  = 3'h2;
    localparam logic [2:0] OAG_SEG_DATA   = 3'h3;

    // Field widths and positions.
    localparam int OAG_WORD_W     = 32;
    localparam int OAG_HALF_W     = 16;
    localparam int OAG_BYTE_W     = 8;
    localparam int OAG_SEL_W      = 16;
    localparam int OAG_FAR_SEL_LO = 32;
    localparam int OAG_FAR_W      = 48;

    // Values after reset.
    localparam logic [31:0] OAG_RST_WORD = 32'h0000_0000;
    localparam logic [15:0] OAG_RST_SEL  = 16'h0000;

    // Kind of memory reference.
    typedef enum logic [2:0] {
        OAG_REF_FETCH,
        OAG_REF_STACK,
        OAG_REF_DATA,
        OAG_REF_STR_DST
    } oag_ref_e;

    // Displacement width carried by the instruction.
    typedef enum logic [1:0] {
        OAG_DISP_NONE,
        OAG_DISP_8,
        OAG_DISP_16,
        OAG_DISP_32
    } oag_disp_e;

    // Scale factor codes; one means no scaling.
    typedef enum logic [1:0] {
        OAG_SCALE_1,
        OAG_SCALE_2,
        OAG_SCALE_4,
        OAG_SCALE_8
    } oag_scale_e;

    // Arithmetic operation class, for immediate legality.
    typedef enum logic [1:0] {
        OAG_OP_ARITH,
        OAG_OP_UNSIGNED_DIV,
        OAG_OP_SIGNED_QUOTIENT,
        OAG_OP_OTHER
    } oag_op_e;

    // One address request from the decoder.
    typedef struct packed {
        logic                valid;
        oag_ref_e            ref_kind;
        logic                addr32;
        logic                ovr_valid;
        logic [2:0]          ovr_seg;
        logic                base_valid;
        logic [2:0]          base_reg;
        logic                index_valid;
        logic [2:0]          index_reg;
        oag_scale_e          scale;
        oag_disp_e           disp_size;
        logic [31:0]         disp;
    } oag_req_s;

    // Immediate and operand-format request.
    typedef struct packed {
        logic                valid;
        oag_op_e             op;
        logic                imm_valid;
        logic [31:0]         imm;
        logic [31:0]         imm_max;
        logic                sel_from_mem;
        logic [15:0]         sel_mem;
        logic [2:0]          sel_reg;
        logic [47:0]         far_mem;
    } oag_opnd_s;

    // Address result.
    typedef struct packed {
        logic                valid;
        logic                fault;
        logic [2:0]          seg;
        logic [31:0]         offset;
    } oag_addr_s;

    // Operand-format result.
    typedef struct packed {
        logic                valid;
        logic                imm_fault;
        logic [31:0]         imm;
        logic [63:0]         pair;
        logic [15:0]         sel;
        logic [31:0]         far_off;
        logic [15:0]         far_sel;
    } oag_opres_s;

endpackage

`default_nettype wire

// File: src/oag_seg_select.sv
/*
 * Segment selection for one memory reference: defaults by reference kind
 * and base register, then a prefix override where one is allowed.
 * Assumes the override segment number is a legal segment register.
 */
`timescale 1ns/1ps
`default_nettype none

module oag_seg_select (
    // Reference description.
    input  wire oag_pkg::oag_ref_e ref_kind,
    input  wire logic              base_valid,
    input  wire logic [2:0]        base_reg,
    input  wire logic              ovr_valid,
    input  wire logic [2:0]        ovr_seg,
    // Chosen segment register.
    output logic [2:0]             seg
);
    import oag_pkg::*;

    // Fixed kinds ignore the prefix; data references take it.
    always_comb begin
        seg = OAG_SEG_DATA;
        unique case (ref_kind)
            OAG_REF_FETCH:   seg = OAG_SEG_CODE;
            OAG_REF_STACK:   seg = OAG_SEG_STACK;
            OAG_REF_STR_DST: seg = OAG_SEG_STRING;
            default: begin
                if (base_valid && (base_reg == OAG_REG_STACK_PTR ||
                                   base_reg == OAG_REG_FRAME_BAS)) begin
                    seg = OAG_SEG_STACK;
                end else begin
                    seg = OAG_SEG_DATA;
                end
                if (ovr_valid) begin
                    seg = ovr_seg;
                end
            end
        endcase
    end

endmodule

`default_nettype wire

// File: src/oag_ea_adder.sv
/*
 * Effective address adder: sign-extended displacement, base and scaled
 * index summed and cut to the active address size.
 * Assumes register values are already read from the register file.
 */
`timescale 1ns/1ps
`default_nettype none

module oag_ea_adder (
    // Components.
    input  wire logic               addr32,
    input  wire oag_pkg::oag_disp_e disp_size,
    input  wire logic [31:0]        disp,
    input  wire logic               base_valid,
    input  wire logic [31:0]        base_val,
    input  wire logic               index_valid,
    input  wire oag_pkg::oag_scale_e scale,
    input  wire logic [31:0]        index_val,
    // Offset within the segment.
    output logic [31:0]             offset
);
    import oag_pkg::*;

    logic [31:0] disp_ext;
    logic [31:0] base_term;
    logic [31:0] index_term;
    logic [31:0] sum;

    // Extend the displacement from its encoded width.
    always_comb begin
        disp_ext = OAG_RST_WORD;
        unique case (disp_size)
            OAG_DISP_NONE: disp_ext = OAG_RST_WORD;
            OAG_DISP_8:    disp_ext = {{24{disp[7]}}, disp[7:0]};
            OAG_DISP_16:   disp_ext = {{16{disp[15]}}, disp[15:0]};
            OAG_DISP_32:   disp_ext = disp;
        endcase
        if (!addr32) begin
            disp_ext = {16'h0000, disp_ext[15:0]};
        end
    end

    // Absent parts add nothing; scale only touches a present index.
    always_comb begin
        base_term  = base_valid ? base_val : OAG_RST_WORD;
        index_term = OAG_RST_WORD;
        if (index_valid) begin
            index_term = index_val << scale;
        end
    end

    // Two's complement wraps, so signed parts add as plain words.
    assign sum = disp_ext + base_term + index_term;

    // Carries above the address size are dropped.
    assign offset = addr32 ? sum : {16'h0000, sum[15:0]};

endmodule

`default_nettype wire

// File: testbench/oag_top_props.sv
/* Checker for oag_top: segment choice, faults and operand fields at the ports.
   Assumes it is bound to every oag_top instance. */
`timescale 1ns/1ps
`default_nettype none
module oag_top_props (
    // Clock and reset.
    input wire logic                clk,
    input wire logic                rst,
    // Requests and register values.
    input wire oag_pkg::oag_req_s   req,
    input wire oag_pkg::oag_opnd_s  opnd,
    input wire logic [31:0]         low_accumulator_register,
    input wire logic [31:0]         high_data_pair_register,
    // Results.
    input wire logic [2:0]          gpr_rd_a,
    input wire logic [2:0]          gpr_rd_b,
    input wire oag_pkg::oag_addr_s  addr_out,
    input wire oag_pkg::oag_opres_s opnd_out
);
    import oag_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Request shapes that lead to an override or a fault.
    sequence s_data_ovr;
        req.valid && req.ref_kind == OAG_REF_DATA && req.ovr_valid;
    endsequence
    sequence s_sp_index;
        req.valid && req.index_valid && req.index_reg == OAG_REG_STACK_PTR;
    endsequence
    a_fetch_code: assert property (req.valid && req.ref_kind == OAG_REF_FETCH
        |=> addr_out.seg == OAG_SEG_CODE) else $error("fetch segment wrong");
    a_stack_seg: assert property (req.valid && req.ref_kind == OAG_REF_STACK
        |=> addr_out.seg == OAG_SEG_STACK) else $error("stack segment wrong");
    a_string_dst: assert property (req.valid && req.ref_kind == OAG_REF_STR_DST
        |=> addr_out.seg == OAG_SEG_STRING) else $error("string segment wrong");
    a_ovr_wins: assert property (s_data_ovr |=> addr_out.seg == $past(req.ovr_seg))
        else $error("override ignored");
    a_sp_fault: assert property (s_sp_index |=> addr_out.fault && addr_out.offset == 32'h0)
        else $error("stack pointer index accepted");
    a_short_addr: assert property (req.valid && !req.addr32 |=> addr_out.offset[31:16] == 16'h0)
        else $error("short offset too wide");
    a_valid_follow: assert property (addr_out.valid == $past(req.valid))
        else $error("address valid out of step");
    a_pair_order: assert property (opnd.valid |=> opnd_out.pair ==
        {$past(high_data_pair_register), $past(low_accumulator_register)}) else $error("pair order");
    a_far_split: assert property (opnd.valid |=>
        {opnd_out.far_sel, opnd_out.far_off} == $past(opnd.far_mem)) else $error("far pointer split");
    a_div_refuse: assert property (opnd.valid && opnd.imm_valid && opnd.op inside
        {OAG_OP_UNSIGNED_DIV, OAG_OP_SIGNED_QUOTIENT} |=> opnd_out.imm_fault)
        else $error("divide immediate accepted");
    a_gpr_route: assert property (gpr_rd_a == req.base_reg && gpr_rd_b == req.index_reg)
        else $error("register read port wrong");
endmodule
bind oag_top oag_top_props oag_top_props_inst (
    .clk(clk), .rst(rst), .req(req), .opnd(opnd),
    .low_accumulator_register(low_accumulator_register),
    .high_data_pair_register(high_data_pair_register),
    .gpr_rd_a(gpr_rd_a), .gpr_rd_b(gpr_rd_b), .addr_out(addr_out), .opnd_out(opnd_out));
`default_nettype wire

// File: testbench/test_oag_top.sv
/* Self-checking bench for oag_top with random address and operand requests.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
`default_nettype none
module test_oag_top;
    import oag_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    oag_req_s    req = '0;
    oag_opnd_s   opnd = '0;
    logic [2:0]  rd_a, rd_b;
    logic [31:0] gpr [8];
    logic [31:0] lo = 32'h0;
    logic [31:0] hi = 32'h0;
    logic [15:0] half_sel = 16'h0;
    oag_addr_s   addr_out;
    oag_opres_s  opnd_out;
    oag_addr_s   q_a [$];
    oag_opres_s  q_o [$];
    int          n_errors = 0;
    int          n_checks = 0;

    oag_top oag_top_inst (.clk(clk), .rst(rst), .req(req), .opnd(opnd), .gpr_rd_a(rd_a),
        .gpr_rd_b(rd_b), .gpr_val_a(gpr[rd_a]), .gpr_val_b(gpr[rd_b]),
        .low_accumulator_register(lo), .high_data_pair_register(hi),
        .gpr_half_sel(half_sel), .addr_out(addr_out), .opnd_out(opnd_out));

    // Free-running clock.
    initial begin
        forever #5 clk = ~clk;
    end

    // Counts a comparison and reports a difference.
    task automatic chk(input logic [161:0] seen, input logic [161:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic summarize;
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Expected segment and offset for one address request.
    function automatic oag_addr_s exp_addr(input oag_req_s r);
        oag_addr_s   e;
        logic [31:0] d;
        e = '0;
        e.valid = 1'b1;
        case (r.ref_kind)
            OAG_REF_FETCH:   e.seg = OAG_SEG_CODE;
            OAG_REF_STACK:   e.seg = OAG_SEG_STACK;
            OAG_REF_STR_DST: e.seg = OAG_SEG_STRING;
            default: e.seg = r.ovr_valid ? r.ovr_seg : (r.base_valid && r.base_reg inside
                {OAG_REG_STACK_PTR, OAG_REG_FRAME_BAS}) ? OAG_SEG_STACK : OAG_SEG_DATA;
        endcase
        case (r.disp_size)
            OAG_DISP_8:  d = {{24{r.disp[7]}}, r.disp[7:0]};
            OAG_DISP_16: d = {{16{r.disp[15]}}, r.disp[15:0]};
            OAG_DISP_32: d = r.disp;
            default:     d = 32'h0;
        endcase
        d = d + (r.base_valid ? gpr[r.base_reg] : 32'h0)
              + (r.index_valid ? gpr[r.index_reg] << r.scale : 32'h0);
        e.offset = r.addr32 ? d : {16'h0, d[15:0]};
        if (r.index_valid && r.index_reg == OAG_REG_STACK_PTR) begin
            e.fault = 1'b1;
            e.offset = 32'h0;
        end
        return e;
    endfunction

    // Random requests; every valid one leaves its expected result in a queue.
    initial begin
        oag_req_s    r;
        oag_opnd_s   o;
        oag_opres_s  e;
        void'($urandom(32'hD01CC9CC));
        foreach (gpr[i]) gpr[i] = $urandom;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(162'(addr_out), '0);
        repeat (600) begin
            @(posedge clk);
            r = ($bits(oag_req_s))'({$urandom, $urandom});
            r.ref_kind[2] = 1'b0;
            r.ovr_seg[2] = 1'b0;
            if (!r.addr32 && r.disp_size == OAG_DISP_32) r.disp_size = OAG_DISP_16;
            req <= r;
            if (r.valid) q_a.push_back(exp_addr(r));
            o = ($bits(oag_opnd_s))'({$urandom, $urandom, $urandom, $urandom, $urandom});
            o.imm_valid = 1'b1;
            if (o.op == OAG_OP_OTHER) o.op = OAG_OP_ARITH;
            if (o.sel_reg[0]) o.imm_max = o.imm;
            e = '0;
            e.valid = 1'b1;
            e.imm_fault = o.op != OAG_OP_ARITH || o.imm > o.imm_max;
            e.imm = e.imm_fault ? 32'h0 : o.imm;
            e.pair = {$urandom, $urandom};
            e.sel = o.sel_from_mem ? o.sel_mem : 16'($urandom);
            {e.far_sel, e.far_off} = o.far_mem;
            opnd <= o;
            {hi, lo} <= e.pair;
            half_sel <= e.sel;
            if (o.valid) q_o.push_back(e);
        end
        @(posedge clk);
        req <= '0;
        opnd <= '0;
        repeat (3) @(posedge clk);
        chk(162'(q_a.size() + q_o.size()), '0);
        summarize();
    end

    // Compares each answer with the oldest expectation.
    always @(posedge clk) begin
        if (addr_out.valid === 1'b1) chk(162'(addr_out), 162'(q_a.pop_front()));
        if (opnd_out.valid === 1'b1) chk(opnd_out, q_o.pop_front());
    end

    // Cuts a hang short.
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
